// ---- fpioh_cfg.svh ----
// Register offsets, field positions, reset values and limits of the
// invalid-operand handler. Included by its bare name; holds definitions only.
`ifndef FPIOH_CFG_SVH
`define FPIOH_CFG_SVH

`define FPIOH_OFF_CTRL 8'h00
`define FPIOH_OFF_STAT 8'h04
`define FPIOH_OFF_IADDR 8'h08
`define FPIOH_OFF_EXC0 8'h0c
`define FPIOH_OFF_EXC1 8'h10
`define FPIOH_OFF_EXC2 8'h14

`define FPIOH_CTRL_TRAP_BIT 0
`define FPIOH_STAT_INV_BIT 0
`define FPIOH_STAT_BUSY_BIT 1
`define FPIOH_CTRL_RST 1'h0
`define FPIOH_STAT_RST 1'h0

`define FPIOH_EXP_MAX 15'h7fff
`define FPIOH_EXP_BIAS 17'h03fff
`define FPIOH_K_MAX 7'h11
`define FPIOH_DEF_NAN 80'h7fff_ffff_ffff_ffff_ffff
`define FPIOH_INT_MIN_MAN 64'h8000_0000_0000_0000

`endif

// ---- fpioh_pkg.sv ----
// Types shared by the invalid-operand handler: operations, formats,
// operands, requests and the registered state.
// Assumes the extended format: sign, 15-bit biased exponent, 64-bit mantissa.
package fpioh_pkg;

	typedef enum logic [4:0] {
		OP_ACOS, OP_ASIN, OP_ATANH, OP_ADD, OP_SUB, OP_MUL, OP_SGLMUL,
		OP_DIV, OP_SGLDIV, OP_COS, OP_SIN, OP_SINCOS, OP_TAN, OP_GETEXP,
		OP_GETMAN, OP_LOG10, OP_LOG2, OP_LOGN, OP_LOGNP1, OP_SQRT, OP_MOD,
		OP_REM, OP_SCALE, OP_MOVE, OP_OTHER
	} fpioh_op_type;

	typedef enum logic [2:0] {
		FMT_REAL, FMT_BYTE, FMT_WORD, FMT_LONG, FMT_PACKED
	} fpioh_fmt_type;

	typedef enum logic {DEST_FPREG, DEST_EXT} fpioh_dest_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WRITE = 3'b010,
		ST_TRAP = 3'b100
	} fpioh_fsm_type;

	typedef struct packed {
		logic sign;
		logic [14:0] exp;
		logic [63:0] man;
	} fpioh_ext_type;

	typedef struct packed {
		logic zero;
		logic inf;
		logic nan;
		logic signaling_nan;
		logic neg;
		logic gt1;
	} fpioh_cls_type;

	typedef struct packed {
		fpioh_op_type op;
		fpioh_fmt_type fmt;
		fpioh_dest_type dest;
		fpioh_ext_type src;
		fpioh_ext_type dst;
		logic signed [6:0] k_factor;
		logic [15:0] dec_exp;
	} fpioh_req_type;

	typedef struct packed {
		logic signed [6:0] k_eff;
		logic [3:0] exp_hi;
		logic [11:0] exp_lo;
	} fpioh_pkd_type;

	typedef struct packed {
		fpioh_fsm_type fsm;
		logic trap_en;
		logic inv_flag;
		logic [31:0] iaddr;
		fpioh_ext_type exc;
		fpioh_ext_type result;
		fpioh_pkd_type pkd;
		logic done;
		logic invalid;
		logic fp_write;
		logic ext_write;
		logic trap_pending;
		logic take_exc;
		logic ack;
		logic [31:0] rdata;
	} fpioh_state_type;

endpackage

// ---- fpioh_handler.sv ----
// Invalid-operand detection and default-result unit of a float coprocessor.
// Assumes requests come from logic on clock_i and software uses classic
// Wishbone; one request is taken per idle cycle.
//
// Summary of operation
// RULE1 - Any invalid operand sets the sticky invalid_operation_flag.
// RULE2 - Arc-cosine, arc-sine, atanh flag infinity or magnitude above one.
// RULE3 - Opposite-sign infinity add, same-sign infinity subtract are invalid.
// RULE4 - Zero times infinity, 0/0 and infinity over infinity are invalid.
// RULE5 - Trig, get-exponent and get-mantissa flag an infinite source.
// RULE6 - Logarithms and square root flag any negative source.
// RULE7 - Log of one plus x flags a source below minus one.
// RULE8 - Modulo, remainder flag infinite destination or zero source, no NaN.
// RULE9 - Scale flags an infinite source when the other operand is no NaN.
// RULE10 - Integer conversion flags overflow, quiet NaN or infinite source.
// RULE11 - Packed conversion flags exponent above 999 or k-factor above 17.
// RULE12 - Real-format stores never flag an invalid operand.
// RULE13 - Untrapped overflow or infinity converts to the saturated integer.
// RULE14 - Untrapped NaN converts to its top 8, 16 or 32 significand bits.
// RULE15 - Untrapped k-factor above 17 behaves as k-factor 17.
// RULE16 - Fourth exponent digit goes in upper nibble of third string byte.
// RULE17 - Untrapped error to a float register stores all-ones quiet NaN.
// RULE18 - Trapped store writes its result, then a mid-instruction trap.
// RULE19 - Trapped error leaves the float destination register unchanged.
// RULE20 - The faulting instruction address is latched for the handler.
// RULE21 - Register destination keeps the source as the exceptional operand.
// RULE22 - Host saves the destination address in its own stack frame.
`timescale 1ns/100ps
`include "fpioh_cfg.svh"

module fpioh_handler #(
	parameter int ADDR_WIDTH = 32
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic req_valid_i,
	input wire fpioh_pkg::fpioh_req_type req_i,
	input wire logic [ADDR_WIDTH-1:0] iaddr_i,
	output logic ready_o,
	output logic done_o,
	output logic invalid_o,
	output logic fp_write_o,
	output logic ext_write_o,
	output fpioh_pkg::fpioh_ext_type result_o,
	output fpioh_pkg::fpioh_pkd_type packed_o,
	output logic take_exc_o,
	output logic mid_instr_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	generate
		if (ADDR_WIDTH < 1 || ADDR_WIDTH > 32) begin : g_bad_width
			$error("ADDR_WIDTH must lie between 1 and 32");
		end
	endgenerate

	fpioh_pkg::fpioh_state_type state;
	fpioh_pkg::fpioh_state_type next_state;
	fpioh_pkg::fpioh_cls_type src_cls;
	fpioh_pkg::fpioh_cls_type dst_cls;
	logic accept;
	logic inv;
	logic int_ovf;
	logic [31:0] int_val;
	logic [31:0] iaddr_ext;
	logic [31:0] sat_val;
	logic [31:0] nan_val;

	function automatic fpioh_pkg::fpioh_cls_type classify(
		input fpioh_pkg::fpioh_ext_type x
	);
		fpioh_pkg::fpioh_cls_type c;
		logic top;
		logic frac_nz;
		top = (x.exp == `FPIOH_EXP_MAX);
		frac_nz = (x.man[62:0] != 63'h0);
		c.zero = (x.exp == 15'h0) && (x.man == 64'h0);
		c.inf = top && !frac_nz;
		c.nan = top && frac_nz;
		c.signaling_nan = c.nan && !x.man[62];
		c.neg = x.sign && !c.zero && !c.nan;
		c.gt1 = ({2'h0, x.exp} > `FPIOH_EXP_BIAS) ||
			(({2'h0, x.exp} == `FPIOH_EXP_BIAS) && frac_nz);
		return c;
	endfunction

	// Truncating conversion; flags overflow past the format's signed range
	function automatic logic [32:0] to_int(
		input fpioh_pkg::fpioh_ext_type x,
		input fpioh_pkg::fpioh_fmt_type fmt
	);
		logic signed [16:0] e;
		logic signed [16:0] lim;
		logic [63:0] mag;
		logic [31:0] v;
		logic ovf;
		e = $signed({2'h0, x.exp}) - $signed(`FPIOH_EXP_BIAS);
		case (fmt)
			fpioh_pkg::FMT_BYTE: lim = 17'h00007;
			fpioh_pkg::FMT_WORD: lim = 17'h0000f;
			default: lim = 17'h0001f;
		endcase
		mag = 64'h0;
		ovf = 1'b0;
		if (e > lim) begin
			ovf = 1'b1;
		end else if (e == lim) begin
			ovf = !(x.sign && x.man == `FPIOH_INT_MIN_MAN);
		end
		if (e >= 17'sh0 && !ovf) begin
			mag = x.man >> (6'h3f - e[5:0]);
		end
		v = x.sign ? (32'h0 - mag[31:0]) : mag[31:0];
		return {ovf, v};
	endfunction

	assign src_cls = classify(req_i.src);
	assign dst_cls = classify(req_i.dst);
	assign {int_ovf, int_val} = to_int(req_i.src, req_i.fmt);
	assign iaddr_ext = 32'(iaddr_i);
	assign ready_o = (state.fsm == fpioh_pkg::ST_IDLE);
	assign accept = req_valid_i && ready_o;

	always_comb begin
		case (req_i.fmt)
			fpioh_pkg::FMT_BYTE: begin
				sat_val = req_i.src.sign ? 32'hffff_ff80 : 32'h0000_007f;
				nan_val = {24'h0, req_i.src.man[63:56]};
			end
			fpioh_pkg::FMT_WORD: begin
				sat_val = req_i.src.sign ? 32'hffff_8000 : 32'h0000_7fff;
				nan_val = {16'h0, req_i.src.man[63:48]};
			end
			default: begin
				sat_val = req_i.src.sign ? 32'h8000_0000 : 32'h7fff_ffff;
				nan_val = req_i.src.man[63:32];
			end
		endcase
	end

	always_comb begin
		inv = 1'b0;
		case (req_i.op)
			fpioh_pkg::OP_ACOS, fpioh_pkg::OP_ASIN,
			fpioh_pkg::OP_ATANH: begin
				inv = src_cls.inf || (src_cls.gt1 && !src_cls.nan); // see RULE2
			end
			fpioh_pkg::OP_ADD: begin
				inv = src_cls.inf && dst_cls.inf &&
					(req_i.src.sign != req_i.dst.sign); // see RULE3
			end
			fpioh_pkg::OP_SUB: begin
				inv = src_cls.inf && dst_cls.inf &&
					(req_i.src.sign == req_i.dst.sign); // see RULE3
			end
			fpioh_pkg::OP_MUL, fpioh_pkg::OP_SGLMUL: begin
				inv = (src_cls.zero && dst_cls.inf) ||
					(src_cls.inf && dst_cls.zero); // see RULE4
			end
			fpioh_pkg::OP_DIV, fpioh_pkg::OP_SGLDIV: begin
				inv = (src_cls.zero && dst_cls.zero) ||
					(src_cls.inf && dst_cls.inf); // see RULE4
			end
			fpioh_pkg::OP_COS, fpioh_pkg::OP_SIN, fpioh_pkg::OP_SINCOS,
			fpioh_pkg::OP_TAN, fpioh_pkg::OP_GETEXP,
			fpioh_pkg::OP_GETMAN: begin
				inv = src_cls.inf; // see RULE5
			end
			fpioh_pkg::OP_LOG10, fpioh_pkg::OP_LOG2, fpioh_pkg::OP_LOGN,
			fpioh_pkg::OP_SQRT: begin
				inv = src_cls.neg; // see RULE6
			end
			fpioh_pkg::OP_LOGNP1: begin
				inv = src_cls.neg && src_cls.gt1; // see RULE7
			end
			fpioh_pkg::OP_MOD, fpioh_pkg::OP_REM: begin
				inv = (dst_cls.inf || src_cls.zero) &&
					!src_cls.nan && !dst_cls.nan; // see RULE8
			end
			fpioh_pkg::OP_SCALE: begin
				inv = src_cls.inf && !dst_cls.nan; // see RULE9
			end
			fpioh_pkg::OP_MOVE: begin
				case (req_i.fmt)
					fpioh_pkg::FMT_REAL: inv = 1'b0; // see RULE12
					fpioh_pkg::FMT_PACKED: begin
						inv = (req_i.dec_exp[15:12] != 4'h0) ||
							(req_i.k_factor > $signed(`FPIOH_K_MAX)); // see RULE11
					end
					default: begin
						inv = src_cls.inf || (src_cls.nan && !src_cls.signaling_nan) ||
							(int_ovf && !src_cls.nan); // see RULE10
					end
				endcase
			end
			default: inv = 1'b0;
		endcase
	end

	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		next_state.fp_write = 1'b0;
		next_state.ext_write = 1'b0;
		next_state.take_exc = 1'b0;
		next_state.ack = wb_cyc_i && wb_stb_i && !state.ack;

		case (state.fsm)
			fpioh_pkg::ST_IDLE: begin
				if (accept) begin
					next_state.fsm = fpioh_pkg::ST_WRITE;
					next_state.done = 1'b1;
					next_state.invalid = inv;
					next_state.trap_pending = inv && state.trap_en &&
						req_i.op == fpioh_pkg::OP_MOVE &&
						req_i.dest == fpioh_pkg::DEST_EXT; // see RULE18
					if (inv) begin
						next_state.iaddr = iaddr_ext; // see RULE20
					end
					if (req_i.dest == fpioh_pkg::DEST_FPREG) begin
						next_state.result = `FPIOH_DEF_NAN; // see RULE17
						// Trapped errors leave the register to the handler
						next_state.fp_write = inv && !state.trap_en; // see RULE19
						if (inv) begin
							next_state.exc = req_i.src; // see RULE21
						end
					end else if (req_i.op == fpioh_pkg::OP_MOVE) begin
						next_state.ext_write = 1'b1;
						case (req_i.fmt)
							fpioh_pkg::FMT_REAL: begin
								next_state.result = req_i.src;
							end
							fpioh_pkg::FMT_PACKED: begin
								next_state.result = '0;
								next_state.pkd.exp_hi = req_i.dec_exp[15:12]; // see RULE16
								next_state.pkd.exp_lo = req_i.dec_exp[11:0]; // see RULE16
								if (req_i.k_factor > $signed(`FPIOH_K_MAX)) begin
									next_state.pkd.k_eff = `FPIOH_K_MAX; // see RULE15
								end else begin
									next_state.pkd.k_eff = req_i.k_factor;
								end
							end
							default: begin
								if (src_cls.nan) begin
									next_state.result = {48'h0, nan_val}; // see RULE14
								end else if (src_cls.inf || int_ovf) begin
									next_state.result = {48'h0, sat_val}; // see RULE13
								end else begin
									next_state.result = {48'h0, int_val};
								end
							end
						endcase
					end
				end
			end
			fpioh_pkg::ST_WRITE: begin
				// Result is out before the exception is signalled
				if (state.trap_pending) begin
					next_state.fsm = fpioh_pkg::ST_TRAP;
					next_state.take_exc = 1'b1; // see RULE18
				end else begin
					next_state.fsm = fpioh_pkg::ST_IDLE;
				end
			end
			fpioh_pkg::ST_TRAP: begin
				next_state.fsm = fpioh_pkg::ST_IDLE;
				next_state.trap_pending = 1'b0;
			end
			default: next_state.fsm = fpioh_pkg::ST_IDLE;
		endcase

		// Write takes effect on the edge where the master samples ack
		if (wb_cyc_i && wb_stb_i && wb_we_i && state.ack && wb_sel_i[0]) begin
			if (wb_adr_i == `FPIOH_OFF_CTRL) begin
				next_state.trap_en = wb_dat_i[`FPIOH_CTRL_TRAP_BIT];
			end
			if (wb_adr_i == `FPIOH_OFF_STAT &&
				wb_dat_i[`FPIOH_STAT_INV_BIT]) begin
				next_state.inv_flag = 1'b0;
			end
		end
		// A new error in the clearing cycle keeps the flag set
		if (accept && inv) begin
			next_state.inv_flag = 1'b1; // see RULE1
		end

		next_state.rdata = 32'h0;
		if (wb_cyc_i && wb_stb_i && !state.ack && !wb_we_i) begin
			case (wb_adr_i)
				`FPIOH_OFF_CTRL: begin
					next_state.rdata[`FPIOH_CTRL_TRAP_BIT] = state.trap_en;
				end
				`FPIOH_OFF_STAT: begin
					next_state.rdata[`FPIOH_STAT_INV_BIT] = state.inv_flag;
					next_state.rdata[`FPIOH_STAT_BUSY_BIT] = !ready_o;
				end
				`FPIOH_OFF_IADDR: next_state.rdata = state.iaddr;
				`FPIOH_OFF_EXC0: next_state.rdata = state.exc.man[31:0];
				`FPIOH_OFF_EXC1: next_state.rdata = state.exc.man[63:32];
				`FPIOH_OFF_EXC2: begin
					next_state.rdata = {16'h0, state.exc.sign, state.exc.exp};
				end
				default: next_state.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state <= '0;
			state.fsm <= fpioh_pkg::ST_IDLE;
			state.trap_en <= `FPIOH_CTRL_RST;
			state.inv_flag <= `FPIOH_STAT_RST;
		end else begin
			state <= next_state;
		end
	end

	assign done_o = state.done;
	assign invalid_o = state.invalid;
	assign fp_write_o = state.fp_write;
	assign ext_write_o = state.ext_write;
	assign result_o = state.result;
	assign packed_o = state.pkd;
	assign take_exc_o = state.take_exc;
	assign mid_instr_o = state.take_exc;
	assign wb_dat_o = state.rdata;
	assign wb_ack_o = state.ack;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);

	AST_FLAG_SET: assert property ( // see RULE1
		accept && inv |=> state.inv_flag && invalid_o && done_o)
		else $error("invalid flag not set");
	AST_TRIG_RANGE: assert property ( // see RULE2
		accept && req_i.op == fpioh_pkg::OP_ACOS && src_cls.gt1 &&
		!src_cls.nan |=> invalid_o)
		else $error("arc-cosine range missed");
	AST_ADD_INF: assert property ( // see RULE3
		accept && req_i.op == fpioh_pkg::OP_ADD && src_cls.inf &&
		dst_cls.inf && req_i.src.sign != req_i.dst.sign |=> invalid_o)
		else $error("infinity add missed");
	AST_MUL_ZERO_INF: assert property ( // see RULE4
		accept && req_i.op == fpioh_pkg::OP_MUL && src_cls.zero &&
		dst_cls.inf |=> invalid_o)
		else $error("zero times infinity missed");
	AST_SQRT_NEG: assert property ( // see RULE6
		accept && req_i.op == fpioh_pkg::OP_SQRT && src_cls.neg |=> invalid_o)
		else $error("negative root missed");
	AST_REAL_STORE: assert property ( // see RULE12
		accept && req_i.op == fpioh_pkg::OP_MOVE &&
		req_i.fmt == fpioh_pkg::FMT_REAL |=> (!invalid_o && !state.take_exc) [*2])
		else $error("real store flagged");
	AST_INT_SAT: assert property ( // see RULE13
		accept && req_i.op == fpioh_pkg::OP_MOVE &&
		req_i.fmt == fpioh_pkg::FMT_LONG && req_i.dest == fpioh_pkg::DEST_EXT &&
		src_cls.inf && !req_i.src.sign |=> result_o[31:0] == 32'h7fff_ffff &&
		ext_write_o) else $error("saturation wrong");
	AST_K_CLAMP: assert property ( // see RULE15
		accept && req_i.op == fpioh_pkg::OP_MOVE &&
		req_i.fmt == fpioh_pkg::FMT_PACKED && req_i.dest == fpioh_pkg::DEST_EXT &&
		req_i.k_factor > $signed(`FPIOH_K_MAX)
		|=> packed_o.k_eff == `FPIOH_K_MAX) else $error("k-factor not clamped");
	AST_FPREG_NAN: assert property ( // see RULE17
		accept && inv && !state.trap_en &&
		req_i.dest == fpioh_pkg::DEST_FPREG |=> fp_write_o &&
		result_o == `FPIOH_DEF_NAN) else $error("default NaN not stored");
	AST_TRAP_ORDER: assert property ( // see RULE18
		take_exc_o |-> mid_instr_o && $past(ext_write_o) && !ext_write_o)
		else $error("exception before result write");
	AST_FPREG_KEEP: assert property ( // see RULE19
		accept && inv && state.trap_en &&
		req_i.dest == fpioh_pkg::DEST_FPREG |=> !fp_write_o ##1 !fp_write_o)
		else $error("trapped register written");
	AST_IADDR: assert property ( // see RULE20
		accept && inv |=> state.iaddr == $past(iaddr_ext))
		else $error("instruction address not kept");

	COV_MID_TRAP: cover property (accept && inv && state.trap_en ##1
		ext_write_o ##1 take_exc_o);
	COV_DEF_NAN: cover property (fp_write_o && invalid_o);
	COV_FLAG_CLEAR: cover property (state.inv_flag ##1 !state.inv_flag);

endmodule

// ---- fpioh_host_model.sv ----
// Host processor model: issues one operation request at a time and keeps
// the word at offset 0x10 of its mid-instruction frame.
// Assumes the handler's ready/valid request handshake on clock_i.
`timescale 1ns/100ps

module fpioh_host_model (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic ready_i,
	input wire logic take_exc_i,
	output logic req_valid_o,
	output fpioh_pkg::fpioh_req_type req_o,
	output logic [31:0] iaddr_o,
	output logic [31:0] frame_ea_o
);
	logic [31:0] ea;

	initial begin
		req_valid_o = 1'h0;
		req_o = '0;
		iaddr_o = 32'h0;
		ea = 32'h0;
	end

	// Evaluated destination address saved for the handler on a trap
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			frame_ea_o <= 32'h0;
		end else if (take_exc_i) begin
			frame_ea_o <= ea;
		end
	end

	// Holds the request until the edge that sees ready high
	task automatic issue(input fpioh_pkg::fpioh_req_type r,
			input logic [31:0] ia, input logic [31:0] dest_ea);
		@(posedge clock_i);
		req_valid_o <= 1'h1;
		req_o <= r;
		iaddr_o <= ia;
		ea <= dest_ea;
		@(posedge clock_i);
		while (ready_i !== 1'h1) begin
			@(posedge clock_i);
		end
		req_valid_o <= 1'h0;
		req_o <= ~r;
		iaddr_o <= ~ia;
	endtask
endmodule

// ---- fpioh_handler_bench.sv ----
// Self-checking bench of the invalid-operand handler.
// Assumes a 10 MHz clock and classic Wishbone register access.
`timescale 1ns/100ps
`include "fpioh_cfg.svh"

module fpioh_handler_bench;
	localparam logic [79:0] PINF = 80'h7fff_0000_0000_0000_0000;
	localparam logic [79:0] NINF = 80'hffff_0000_0000_0000_0000;
	localparam logic [79:0] ONE = 80'h3fff_8000_0000_0000_0000;
	localparam logic [79:0] NONE = 80'hbfff_8000_0000_0000_0000;
	localparam logic [79:0] TWO = 80'h4000_8000_0000_0000_0000;
	localparam logic [79:0] NTWO = 80'hc000_8000_0000_0000_0000;
	localparam logic [79:0] ZERO = 80'h0;
	localparam logic [79:0] QNAN = 80'h7fff_c123_4567_89ab_cdef;
	localparam logic [79:0] BIG = 80'h4027_8000_0000_0000_0000;
	localparam logic [79:0] NBIG = 80'hc013_8000_0000_0000_0000;
	logic clock_i, arst_n_i, req_valid, ready, done, invalid, fp_write;
	logic ext_write, take_exc, mid_instr, wb_cyc, wb_stb, wb_we, wb_ack;
	logic trap;
	fpioh_pkg::fpioh_req_type req;
	fpioh_pkg::fpioh_ext_type result;
	fpioh_pkg::fpioh_pkd_type pkd;
	logic [31:0] iaddr, wb_dat_w, wb_dat_r, frame_ea, iaddr_v, ea_v;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic signed [6:0] k_v;
	logic [15:0] dexp_v;
	int err_total, n_compared;

	fpioh_handler u_fpioh_handler (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.req_valid_i(req_valid), .req_i(req), .iaddr_i(iaddr),
		.ready_o(ready), .done_o(done), .invalid_o(invalid),
		.fp_write_o(fp_write), .ext_write_o(ext_write), .result_o(result),
		.packed_o(pkd), .take_exc_o(take_exc), .mid_instr_o(mid_instr),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
		.wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack));

	fpioh_host_model u_fpioh_host_model (.clock_i(clock_i),
		.arst_n_i(arst_n_i), .ready_i(ready), .take_exc_i(take_exc),
		.req_valid_o(req_valid), .req_o(req), .iaddr_o(iaddr),
		.frame_ea_o(frame_ea));

	initial begin
		clock_i = 1'h0;
		forever #50 clock_i = ~clock_i;
	end

	task automatic end_of_test();
		if (err_total == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cmp_bit(input logic g, input logic e, input string m);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task automatic cmp_val(input logic [79:0] g, input logic [79:0] e,
			input string m);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("mismatch at %0t: %s got %h", $time, m, g);
		end
	endtask

	task automatic wb_io(input logic we, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clock_i);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= a;
		wb_sel <= 4'hf;
		wb_dat_w <= wd;
		// Read data is taken at the edge that samples ack high
		@(posedge clock_i);
		while (wb_ack !== 1'h1) begin
			@(posedge clock_i);
		end
		rd = wb_dat_r;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
		wb_we <= 1'h0;
		wb_dat_w <= ~wd;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wb_io(1'h1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] mask,
			input logic [31:0] e);
		logic [31:0] x;
		wb_io(1'h0, a, 32'h0, x);
		cmp_val({48'h0, x & mask}, {48'h0, e}, "register read");
	endtask

	task automatic go(input fpioh_pkg::fpioh_op_type op,
			input fpioh_pkg::fpioh_fmt_type fmt, input logic ext,
			input logic [79:0] s, input logic [79:0] d, input logic inv);
		fpioh_pkg::fpioh_req_type r;
		logic fw;
		r = '{op, fmt, ext ? fpioh_pkg::DEST_EXT : fpioh_pkg::DEST_FPREG,
			s, d, k_v, dexp_v};
		fw = !ext & inv & !trap;
		iaddr_v = iaddr_v + 32'h4;
		ea_v = ea_v + 32'h10;
		u_fpioh_host_model.issue(r, iaddr_v, ea_v);
		@(negedge clock_i);
		cmp_bit(done, 1'h1, "done");
		cmp_bit(invalid, inv, "invalid");
		cmp_bit(fp_write, fw, "fp write");
		cmp_bit(ext_write, ext, "ext write");
		if (fw) cmp_val(result, `FPIOH_DEF_NAN, "nan");
		@(negedge clock_i);
		cmp_bit(take_exc, ext & inv & trap, "take");
		cmp_bit(mid_instr, ext & inv & trap, "mid");
		while (!ready) begin
			@(negedge clock_i);
		end
	endtask

	initial begin
		#1000000;
		err_total++;
		end_of_test();
	end

	initial begin
		arst_n_i = 1'h0;
		{wb_cyc, wb_stb, wb_we, trap} = 4'h0;
		wb_adr = 8'h0;
		wb_sel = 4'hf;
		wb_dat_w = 32'h0;
		{iaddr_v, ea_v} = 64'h0;
		k_v = 7'h0;
		dexp_v = 16'h0;
		err_total = 0;
		n_compared = 0;
		repeat (2) @(posedge clock_i);
		arst_n_i <= 1'h1;
		rd(`FPIOH_OFF_CTRL, 32'h1, 32'h0);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'hffff_ffff, 32'h0);
		go(fpioh_pkg::OP_ACOS, fpioh_pkg::FMT_REAL, 0, TWO, ZERO, 1);
		go(fpioh_pkg::OP_ASIN, fpioh_pkg::FMT_REAL, 0, NINF, ZERO, 1);
		go(fpioh_pkg::OP_ATANH, fpioh_pkg::FMT_REAL, 0, NTWO, ZERO, 1);
		go(fpioh_pkg::OP_ACOS, fpioh_pkg::FMT_REAL, 0, ONE, ZERO, 0);
		go(fpioh_pkg::OP_ADD, fpioh_pkg::FMT_REAL, 0, PINF, NINF, 1);
		go(fpioh_pkg::OP_ADD, fpioh_pkg::FMT_REAL, 0, PINF, PINF, 0);
		go(fpioh_pkg::OP_SUB, fpioh_pkg::FMT_REAL, 0, NINF, NINF, 1);
		go(fpioh_pkg::OP_SUB, fpioh_pkg::FMT_REAL, 0, PINF, NINF, 0);
		go(fpioh_pkg::OP_MUL, fpioh_pkg::FMT_REAL, 0, ZERO, NINF, 1);
		go(fpioh_pkg::OP_SGLMUL, fpioh_pkg::FMT_REAL, 0, PINF, ZERO, 1);
		go(fpioh_pkg::OP_DIV, fpioh_pkg::FMT_REAL, 0, ZERO, ZERO, 1);
		go(fpioh_pkg::OP_SGLDIV, fpioh_pkg::FMT_REAL, 0, PINF, NINF, 1);
		for (int i = 9; i <= 14; i++) begin
			go(fpioh_pkg::fpioh_op_type'(i), fpioh_pkg::FMT_REAL, 0,
				i[0] ? PINF : NINF, ONE, 1);
		end
		go(fpioh_pkg::OP_COS, fpioh_pkg::FMT_REAL, 0, TWO, ONE, 0);
		for (int i = 15; i <= 19; i++) begin
			go(fpioh_pkg::fpioh_op_type'(i), fpioh_pkg::FMT_REAL, 0,
				i == 18 ? NTWO : NONE, ONE, 1);
		end
		go(fpioh_pkg::OP_LOGNP1, fpioh_pkg::FMT_REAL, 0, NONE, ONE, 0);
		go(fpioh_pkg::OP_SQRT, fpioh_pkg::FMT_REAL, 0, NINF, ONE, 1);
		go(fpioh_pkg::OP_MOD, fpioh_pkg::FMT_REAL, 0, ONE, NINF, 1);
		go(fpioh_pkg::OP_REM, fpioh_pkg::FMT_REAL, 0, ZERO, ONE, 1);
		go(fpioh_pkg::OP_MOD, fpioh_pkg::FMT_REAL, 0, QNAN, PINF, 0);
		go(fpioh_pkg::OP_SCALE, fpioh_pkg::FMT_REAL, 0, PINF, ONE, 1);
		go(fpioh_pkg::OP_SCALE, fpioh_pkg::FMT_REAL, 0, PINF, QNAN, 0);
		rd(`FPIOH_OFF_STAT, 32'h1, 32'h1);
		wr(`FPIOH_OFF_STAT, 32'h1);
		rd(`FPIOH_OFF_STAT, 32'h1, 32'h0);
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_LONG, 1, PINF, ZERO, 1);
		cmp_val(result[31:0], 32'h7fff_ffff, "long inf");
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_WORD, 1, NBIG, ZERO, 1);
		cmp_val(result[15:0], 16'h8000, "word overflow");
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_BYTE, 1, NINF, ZERO, 1);
		cmp_val(result[7:0], 8'h80, "byte inf");
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_LONG, 1, BIG, ZERO, 1);
		cmp_val(result[31:0], 32'h7fff_ffff, "long overflow");
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_LONG, 1, QNAN, ZERO, 1);
		cmp_val(result[31:0], 32'hc123_4567, "long nan");
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_WORD, 1, QNAN, ZERO, 1);
		cmp_val(result[15:0], 16'hc123, "word nan");
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_BYTE, 1, QNAN, ZERO, 1);
		cmp_val(result[7:0], 8'hc1, "byte nan");
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_BYTE, 1, TWO, ZERO, 0);
		cmp_val(result[7:0], 8'h02, "byte value");
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_REAL, 1, PINF, ZERO, 0);
		cmp_val(result, PINF, "real store");
		k_v = 7'h14;
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_PACKED, 1, ONE, ZERO, 1);
		cmp_val(pkd.k_eff, `FPIOH_K_MAX, "k clamp");
		k_v = 7'h11;
		dexp_v = 16'h1234;
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_PACKED, 1, ONE, ZERO, 1);
		cmp_val({pkd.exp_hi, pkd.exp_lo}, 16'h1234, "exp digits");
		dexp_v = 16'h0999;
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_PACKED, 1, ONE, ZERO, 0);
		wr(`FPIOH_OFF_CTRL, 32'h1);
		trap = 1'h1;
		rd(`FPIOH_OFF_CTRL, 32'h1, 32'h1);
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_LONG, 1, PINF, ZERO, 1);
		cmp_val(result[31:0], 32'h7fff_ffff, "trapped store");
		cmp_val(frame_ea, ea_v, "frame address");
		go(fpioh_pkg::OP_MOVE, fpioh_pkg::FMT_LONG, 1, TWO, ZERO, 0);
		go(fpioh_pkg::OP_SQRT, fpioh_pkg::FMT_REAL, 0, NTWO, ONE, 1);
		rd(`FPIOH_OFF_IADDR, 32'hffff_ffff, iaddr_v);
		rd(`FPIOH_OFF_EXC0, 32'hffff_ffff, NTWO[31:0]);
		rd(`FPIOH_OFF_EXC1, 32'hffff_ffff, NTWO[63:32]);
		rd(`FPIOH_OFF_EXC2, 32'hffff_ffff, {16'h0, NTWO[79:64]});
		end_of_test();
	end
endmodule
